// ==== hw/ede_pkg.sv ====
// Shared constants for the data EEPROM operation sequencer and its controller
package ede_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int OP_TIME_NS = 4000;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_WORDS = 256;
  localparam int BIT_WR = 15;
  localparam int BIT_ARM = 14;
  localparam int BIT_ABORT = 13;
  localparam int BIT_SKIP = 12;
  localparam int BIT_ERASE = 6;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h707f;
  localparam logic [5:0] OP_ERASE8 = 6'h1a;
  localparam logic [5:0] OP_ERASE4 = 6'h19;
  localparam logic [5:0] OP_ERASE1 = 6'h18;
  localparam logic [3:0] OP_BULK_HI = 4'h4;
  localparam logic [3:0] OP_WRITE_HI = 4'h1;
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00aa;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic REG_SEL_CTRL = 1'b0;
  localparam logic REG_SEL_KEY = 1'b1;
  localparam logic [7:0] HR_CTRL = 8'h00;
  localparam logic [7:0] HR_ADDR = 8'h04;
  localparam logic [7:0] HR_DATA = 8'h08;
  localparam logic [7:0] HR_GO = 8'h0c;
  localparam logic [7:0] HR_STAT = 8'h10;
  localparam logic [7:0] HR_RDATA = 8'h14;
  localparam int GO_OP_BIT = 0;
  localparam int GO_READ_BIT = 1;
endpackage

// ==== hw/ede_link_if.sv ====
// Link between the processor-side controller and the EEPROM sequencer
`timescale 1ns/1ps
`default_nettype none
interface ede_link_if;
  logic tblWrLo;
  logic tblRdLo;
  logic [23:0] tblAddr;
  logic [15:0] tblWrData;
  logic [15:0] tblRdData;
  logic regWr;
  logic regSel;
  logic [15:0] regWrData;
  logic [15:0] ctrlRd;
  logic doneFlag;
  logic doneClr;
  modport device (input tblWrLo, tblRdLo, tblAddr, tblWrData, regWr, regSel, regWrData,
    doneClr, output tblRdData, ctrlRd, doneFlag);
  modport host (output tblWrLo, tblRdLo, tblAddr, tblWrData, regWr, regSel, regWrData,
    doneClr, input tblRdData, ctrlRd, doneFlag);
endinterface
`default_nettype wire

// ==== hw/ede_op_timer.sv ====
// Cycle timer that paces one erase or program operation
`timescale 1ns/1ps
`default_nettype none
module ede_op_timer #(
  parameter int COUNT = 800,
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic run_r;
  logic run_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done = 1'b0;
    if (abort) begin
      run_nxt = 1'b0;
    end else if (start && !run_r) begin
      run_nxt = 1'b1;
      cnt_nxt = CNT_W'(COUNT - 1);
    end else if (run_r) begin
      if (cnt_r == '0) begin
        run_nxt = 1'b0;
        done = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  assign busy = run_r;
endmodule // ede_op_timer
`default_nettype wire

// ==== hw/ede_eeprom_dev.sv ====
// Data EEPROM operation sequencer: address capture, unlock, erase and write
// Overview of operation
// - Effective address is 24 bits, upper plus lower.
// - Address holders load from last table write.
// - Captured address bit zero forced to zero.
// - Upper holder top bit always zero.
// - Array 16 bits wide, only low word used.
// - Erase 1/4/8 words, bulk, write, read.
// - Low op bits select partial erase size.
// - Host must not read during operation.
// - Partial erase: control, address, flag, key, start; controller writes address and clears flag before control.
// - Completion clears start bit, sets done flag.
// - Bulk erase needs no address setup.
// - Host pre-erases when skip-pre-erase is set.
// - Host loads latch, sets write code, starts.
// - Low table write loads latch and address.
// - Bulk erase control word value is fixed.
// - One-word erase control word value is fixed.
// - Host keeps key writes and start back-to-back.
// - Keys 55h then AAh open one-cycle window.
// - Start bit hardware-cleared; arm cleared on completion.
// - Early reset of an operation sets abort flag.
// - Erase op field decodes 8, 4, 1, bulk.
`timescale 1ns/1ps
`default_nettype none
module ede_eeprom_dev #(
  parameter int EE_WORDS = ede_pkg::EE_WORDS,
  parameter int OP_CYCLES = ede_pkg::OP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic earlyRst,
  ede_link_if.device lnk,
  output logic [7:0] eeprom_addr_upper,
  output logic [15:0] eeprom_addr_lower,
  output logic opBusy
);
  localparam int IW = $clog2(EE_WORDS);

  typedef enum {KEY_IDLE, KEY_HALF, KEY_OPEN} ede_key_t;
  typedef enum {SQ_IDLE, SQ_RUN, SQ_APPLY} ede_seq_t;

  ede_key_t key_r, key_nxt;
  ede_seq_t seq_r, seq_nxt;
  logic [15:0] eeprom_control_r, eeprom_control_nxt;
  logic [7:0] addrU_r, addrU_nxt;
  logic [15:0] addrL_r, addrL_nxt;
  logic [15:0] latch_r, latch_nxt;
  logic [15:0] rdData_r, rdData_nxt;
  logic doneFlag_r, doneFlag_nxt;
  logic [IW-1:0] idx_r, idx_nxt;
  logic [IW:0] left_r, left_nxt;
  logic [15:0] mem [EE_WORDS];
  logic memWe;
  logic [15:0] memWd;
  logic startOk;
  logic tmrBusy;
  logic tmrDone;
  logic [5:0] opField;
  logic [IW-1:0] wordIdx;

  assign opField = eeprom_control_r[5:0];
  assign wordIdx = addrL_r[IW:1];

  ede_op_timer #(.COUNT(OP_CYCLES), .CNT_W($clog2(OP_CYCLES + 1))) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(startOk),
    .abort(earlyRst),
    .busy(tmrBusy),
    .done(tmrDone)
  );

  // Unlock sequence
  always_comb begin
    key_nxt = KEY_IDLE;
    if (lnk.regWr && lnk.regSel == ede_pkg::REG_SEL_KEY) begin
      if (lnk.regWrData == ede_pkg::KEY_FIRST) begin
        key_nxt = KEY_HALF;
      end else if (key_r == KEY_HALF && lnk.regWrData == ede_pkg::KEY_SECOND) begin
        key_nxt = KEY_OPEN;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      key_r <= KEY_IDLE;
    end else begin
      key_r <= key_nxt;
    end
  end

  // Control, address capture, sequencing
  always_comb begin
    eeprom_control_nxt = eeprom_control_r;
    addrU_nxt = addrU_r;
    addrL_nxt = addrL_r;
    latch_nxt = latch_r;
    rdData_nxt = rdData_r;
    doneFlag_nxt = doneFlag_r;
    seq_nxt = seq_r;
    idx_nxt = idx_r;
    left_nxt = left_r;
    startOk = 1'b0;
    memWe = 1'b0;
    memWd = ede_pkg::ERASED_WORD;
    if (lnk.tblWrLo) begin
      addrU_nxt = {1'b0, lnk.tblAddr[22:16]};
      addrL_nxt = {lnk.tblAddr[15:1], 1'b0};
      latch_nxt = lnk.tblWrData;
    end
    if (lnk.tblRdLo) begin
      rdData_nxt = mem[lnk.tblAddr[IW:1]];
    end
    if (lnk.doneClr) begin
      doneFlag_nxt = 1'b0;
    end
    if (lnk.regWr && lnk.regSel == ede_pkg::REG_SEL_CTRL && seq_r == SQ_IDLE) begin
      eeprom_control_nxt = (lnk.regWrData & ede_pkg::CTRL_WMASK)
        | (eeprom_control_r & ~ede_pkg::CTRL_WMASK);
      if (key_r == KEY_OPEN && lnk.regWrData[ede_pkg::BIT_WR]
          && lnk.regWrData[ede_pkg::BIT_ARM]) begin
        startOk = 1'b1;
        eeprom_control_nxt[ede_pkg::BIT_WR] = 1'b1;
        eeprom_control_nxt[ede_pkg::BIT_ABORT] = 1'b0;
        seq_nxt = SQ_RUN;
      end
    end
    case (seq_r)
      SQ_IDLE: begin
      end
      SQ_RUN: begin
        if (tmrDone) begin
          seq_nxt = SQ_APPLY;
          if (!eeprom_control_r[ede_pkg::BIT_ERASE]) begin
            idx_nxt = wordIdx;
            left_nxt = (opField[5:2] == ede_pkg::OP_WRITE_HI) ? (IW+1)'(1) : '0;
          end else if (opField[5:2] == ede_pkg::OP_BULK_HI) begin
            idx_nxt = '0;
            left_nxt = (IW+1)'(EE_WORDS);
          end else if (opField == ede_pkg::OP_ERASE8) begin
            idx_nxt = wordIdx & ~(IW'(7));
            left_nxt = (IW+1)'(8);
          end else if (opField == ede_pkg::OP_ERASE4) begin
            idx_nxt = wordIdx & ~(IW'(3));
            left_nxt = (IW+1)'(4);
          end else if (opField == ede_pkg::OP_ERASE1) begin
            idx_nxt = wordIdx;
            left_nxt = (IW+1)'(1);
          end else begin
            left_nxt = '0;
          end
        end
      end
      SQ_APPLY: begin
        if (left_r != '0) begin
          memWe = 1'b1;
          if (!eeprom_control_r[ede_pkg::BIT_ERASE]) begin
            // With skip set, program-only can clear bits but never set them
            memWd = eeprom_control_r[ede_pkg::BIT_SKIP] ? (mem[idx_r] & latch_r) : latch_r;
          end
          idx_nxt = idx_r + 1'b1;
          left_nxt = left_r - 1'b1;
        end else begin
          seq_nxt = SQ_IDLE;
          eeprom_control_nxt[ede_pkg::BIT_WR] = 1'b0;
          eeprom_control_nxt[ede_pkg::BIT_ARM] = 1'b0;
          doneFlag_nxt = 1'b1;
        end
      end
      default: seq_nxt = SQ_IDLE;
    endcase
    if (earlyRst && seq_r != SQ_IDLE) begin
      seq_nxt = SQ_IDLE;
      memWe = 1'b0;
      eeprom_control_nxt[ede_pkg::BIT_WR] = 1'b0;
      eeprom_control_nxt[ede_pkg::BIT_ARM] = 1'b0;
      eeprom_control_nxt[ede_pkg::BIT_ABORT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eeprom_control_r <= ede_pkg::CTRL_RST;
      addrU_r <= '0;
      addrL_r <= '0;
      latch_r <= '0;
      rdData_r <= '0;
      doneFlag_r <= 1'b0;
      seq_r <= SQ_IDLE;
      idx_r <= '0;
      left_r <= '0;
    end else begin
      eeprom_control_r <= eeprom_control_nxt;
      addrU_r <= addrU_nxt;
      addrL_r <= addrL_nxt;
      latch_r <= latch_nxt;
      rdData_r <= rdData_nxt;
      doneFlag_r <= doneFlag_nxt;
      seq_r <= seq_nxt;
      idx_r <= idx_nxt;
      left_r <= left_nxt;
    end
  end

  // Array contents survive reset
  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      mem[idx_r] <= memWd;
    end
  end

  assign lnk.ctrlRd = eeprom_control_r;
  assign lnk.doneFlag = doneFlag_r;
  assign lnk.tblRdData = rdData_r;
  assign eeprom_addr_upper = addrU_r;
  assign eeprom_addr_lower = addrL_r;
  assign opBusy = (seq_r != SQ_IDLE) || tmrBusy;
endmodule // ede_eeprom_dev
`default_nettype wire

// ==== hw/ede_host_ctl.sv ====
// Processor-side controller that drives table writes, keys and start
`timescale 1ns/1ps
`default_nettype none
module ede_host_ctl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] hostAddr,
  input wire logic [31:0] hostWrData,
  input wire logic hostWr,
  input wire logic hostRd,
  output logic [31:0] hostRdData,
  ede_link_if.host lnk
);
  typedef enum {H_IDLE, H_TBLWT, H_CTRL, H_KEY1, H_KEY2, H_START, H_WAIT, H_READ,
    H_RDCAP} ede_hst_t;

  ede_hst_t st_r, st_nxt;
  logic [15:0] ctrlWord_r, ctrlWord_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] rdWord_r, rdWord_nxt;
  logic doneSeen_r, doneSeen_nxt;
  logic [15:0] out_r, out_nxt;
  logic [31:0] rdq_r, rdq_nxt;

  always_comb begin
    st_nxt = st_r;
    ctrlWord_nxt = ctrlWord_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    rdWord_nxt = rdWord_r;
    doneSeen_nxt = doneSeen_r;
    out_nxt = out_r;
    rdq_nxt = '0;
    if (hostWr && st_r == H_IDLE) begin
      if (hostAddr == ede_pkg::HR_CTRL) ctrlWord_nxt = hostWrData[15:0];
      if (hostAddr == ede_pkg::HR_ADDR) addr_nxt = hostWrData[23:0];
      if (hostAddr == ede_pkg::HR_DATA) data_nxt = hostWrData[15:0];
      if (hostAddr == ede_pkg::HR_GO && hostWrData[ede_pkg::GO_OP_BIT]) begin
        st_nxt = H_TBLWT;
        doneSeen_nxt = 1'b0;
      end else if (hostAddr == ede_pkg::HR_GO && hostWrData[ede_pkg::GO_READ_BIT]) begin
        st_nxt = H_READ;
      end
    end
    if (hostRd) begin
      case (hostAddr)
        ede_pkg::HR_CTRL: rdq_nxt = {16'h0000, ctrlWord_r};
        ede_pkg::HR_ADDR: rdq_nxt = {8'h00, addr_r};
        ede_pkg::HR_DATA: rdq_nxt = {16'h0000, data_r};
        ede_pkg::HR_STAT: rdq_nxt = {28'h0000000, lnk.ctrlRd[ede_pkg::BIT_ABORT],
          lnk.doneFlag, doneSeen_r, st_r != H_IDLE};
        ede_pkg::HR_RDATA: rdq_nxt = {16'h0000, rdWord_r};
        default: rdq_nxt = '0;
      endcase
    end
    case (st_r)
      H_IDLE: begin
      end
      H_TBLWT: begin
        st_nxt = H_CTRL;
        out_nxt = ctrlWord_r & ~(16'h0001 << ede_pkg::BIT_WR);
      end
      H_CTRL: begin
        st_nxt = H_KEY1;
        out_nxt = ede_pkg::KEY_FIRST;
      end
      H_KEY1: begin
        st_nxt = H_KEY2;
        out_nxt = ede_pkg::KEY_SECOND;
      end
      H_KEY2: begin
        st_nxt = H_START;
        out_nxt = ctrlWord_r | (16'h0001 << ede_pkg::BIT_WR);
      end
      H_START: st_nxt = H_WAIT;
      H_WAIT: begin
        if (!lnk.ctrlRd[ede_pkg::BIT_WR]) begin
          st_nxt = H_IDLE;
          doneSeen_nxt = 1'b1;
        end
      end
      H_READ: st_nxt = H_RDCAP;
      H_RDCAP: begin
        st_nxt = H_IDLE;
        rdWord_nxt = lnk.tblRdData;
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= H_IDLE;
      ctrlWord_r <= ede_pkg::CTRL_RST;
      addr_r <= '0;
      data_r <= '0;
      rdWord_r <= '0;
      doneSeen_r <= 1'b0;
      out_r <= '0;
      rdq_r <= '0;
    end else begin
      st_r <= st_nxt;
      ctrlWord_r <= ctrlWord_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      rdWord_r <= rdWord_nxt;
      doneSeen_r <= doneSeen_nxt;
      out_r <= out_nxt;
      rdq_r <= rdq_nxt;
    end
  end

  assign hostRdData = rdq_r;
  assign lnk.tblWrLo = (st_r == H_TBLWT);
  assign lnk.tblRdLo = (st_r == H_READ);
  assign lnk.tblAddr = addr_r;
  assign lnk.tblWrData = data_r;
  assign lnk.regWr = (st_r == H_CTRL) || (st_r == H_KEY1) || (st_r == H_KEY2)
    || (st_r == H_START);
  assign lnk.regSel = (st_r == H_KEY1 || st_r == H_KEY2) ? ede_pkg::REG_SEL_KEY
    : ede_pkg::REG_SEL_CTRL;
  assign lnk.regWrData = out_r;
  assign lnk.doneClr = (st_r == H_TBLWT);
endmodule // ede_host_ctl
`default_nettype wire

// ==== tb/ede_link_checker.sv ====
// Concurrent checks on the link between the controller and the sequencer
`timescale 1ns/1ps
`default_nettype none
module ede_link_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic regWr,
  input wire logic regSel,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] ctrlRd,
  input wire logic doneFlag,
  input wire logic doneClr
);
  localparam int MAX_OP = 600;
  logic aaPrev_r;
  logic aaPrev_nxt;
  logic ctlWr;
  assign ctlWr = regWr && !regSel;
  always_comb begin
    aaPrev_nxt = regWr && regSel && (regWrData == ede_pkg::KEY_SECOND);
  end
  always_ff @(posedge ref_clk) begin
    aaPrev_r <= rst ? 1'b0 : aaPrev_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence unlockStart;
    regWr && regSel && regWrData == ede_pkg::KEY_FIRST ##1 aaPrev_nxt
      ##1 ctlWr && regWrData[15] && regWrData[14] && !ctrlRd[15];
  endsequence
  start_accept_a: assert property (unlockStart |=> ctrlRd[15])
    else $error("start after unlock not taken");
  start_refused_a: assert property (
    ctlWr && regWrData[15] && !ctrlRd[15] && (!aaPrev_r || !regWrData[14]) |=> !ctrlRd[15])
    else $error("start taken without arm or unlock");
  op_bounded_a: assert property ($rose(ctrlRd[15]) |-> ##[1:MAX_OP] !ctrlRd[15])
    else $error("operation never completed");
  op_completion_a: assert property (
    $fell(ctrlRd[15]) |-> (doneFlag || ctrlRd[13]) && !ctrlRd[14])
    else $error("start bit fell without done or abort");
  done_cause_a: assert property ($rose(doneFlag) |-> $fell(ctrlRd[15]))
    else $error("done flag rose without completion");
  done_sticky_a: assert property (doneFlag && !doneClr |=> doneFlag)
    else $error("done flag dropped without clear");
  busy_frozen_a: assert property (ctlWr && ctrlRd[15] |=> $stable(ctrlRd[6:0]))
    else $error("control changed while busy");
  ctrl_write_a: assert property (
    ctlWr && !ctrlRd[15] |=> (ctrlRd & ede_pkg::CTRL_WMASK) ==
      ($past(regWrData) & ede_pkg::CTRL_WMASK))
    else $error("control write not stored");
  cover property (unlockStart);
  cover property ($fell(ctrlRd[15]) && doneFlag);
  cover property ($rose(ctrlRd[13]));
endmodule // ede_link_checker
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for controller and sequencer joined by the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [23:0] addr;
    logic [15:0] data;
    logic [23:0] rdAddr;
    logic [15:0] exp;
  } ede_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic earlyRst = 1'b0;
  logic [7:0] hostAddr = 8'h00;
  logic [31:0] hostWrData = 32'h0;
  logic hostWr = 1'b0;
  logic hostRd = 1'b0;
  logic [31:0] hostRdData;
  logic [7:0] addrUpper;
  logic [15:0] addrLower;
  logic opBusy;
  logic [31:0] s;
  int errors = 0;
  int compares = 0;
  ede_row_t rows [11];
  ede_link_if lnk ();
  ede_link_if lnk2 ();
  ede_host_ctl ede_host_ctl_i (.ref_clk(ref_clk), .rst(rst), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData),
    .lnk(lnk.host));
  ede_eeprom_dev #(.OP_CYCLES(4)) ede_eeprom_dev_i (.ref_clk(ref_clk), .rst(rst),
    .earlyRst(earlyRst), .lnk(lnk.device), .eeprom_addr_upper(addrUpper),
    .eeprom_addr_lower(addrLower), .opBusy(opBusy));
  // Second sequencer, driven directly to break the unlock rules
  ede_eeprom_dev #(.OP_CYCLES(4)) ede_eeprom_dev_b_i (.ref_clk(ref_clk), .rst(rst),
    .earlyRst(1'b0), .lnk(lnk2.device), .eeprom_addr_upper(), .eeprom_addr_lower(),
    .opBusy());
  ede_link_checker ede_link_checker_i (.ref_clk(ref_clk), .rst(rst), .regWr(lnk.regWr),
    .regSel(lnk.regSel), .regWrData(lnk.regWrData), .ctrlRd(lnk.ctrlRd),
    .doneFlag(lnk.doneFlag), .doneClr(lnk.doneClr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hostWr <= 1'b1;
    hostAddr <= a;
    hostWrData <= d;
    @(posedge ref_clk);
    hostWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    hostRd <= 1'b1;
    hostAddr <= a;
    @(posedge ref_clk);
    hostRd <= 1'b0;
    #1 d = hostRdData;
  endtask
  task automatic waitIdle();
    for (int n = 0; n < 600; n++) begin
      rd(ede_pkg::HR_STAT, s);
      if (s[0] === 1'b0) break;
    end
    chk({31'h0, s[0]}, 32'h0);
  endtask
  task automatic runOp(input logic [15:0] c, input logic [23:0] a, input logic [15:0] d);
    wr(ede_pkg::HR_CTRL, {16'h0000, c});
    wr(ede_pkg::HR_ADDR, {8'h00, a});
    wr(ede_pkg::HR_DATA, {16'h0000, d});
    wr(ede_pkg::HR_GO, 32'h1);
  endtask
  // Key, key, control written back to back on the second link
  task automatic seq3(input logic [15:0] k1, input logic [15:0] k2, input logic [15:0] c);
    @(posedge ref_clk);
    lnk2.regWr <= 1'b1;
    lnk2.regSel <= 1'b1;
    lnk2.regWrData <= k1;
    @(posedge ref_clk);
    lnk2.regWrData <= k2;
    @(posedge ref_clk);
    lnk2.regSel <= 1'b0;
    lnk2.regWrData <= c;
    @(posedge ref_clk);
    lnk2.regWr <= 1'b0;
    #1;
  endtask
  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end
  initial begin
    lnk2.tblWrLo = 1'b0;
    lnk2.tblRdLo = 1'b0;
    lnk2.tblAddr = 24'h0;
    lnk2.tblWrData = 16'h0;
    lnk2.regWr = 1'b0;
    lnk2.regSel = 1'b0;
    lnk2.regWrData = 16'h0;
    lnk2.doneClr = 1'b0;
    rows[0] = '{16'h4004, 24'hfffe10, 16'h1234, 24'h7ffe10, 16'h1234};
    rows[1] = '{16'h4004, 24'h7ffe13, 16'habcd, 24'h7ffe12, 16'habcd};
    rows[2] = '{16'h4058, 24'h7ffe10, 16'h0000, 24'h7ffe10, 16'hffff};
    rows[3] = '{16'h4000, 24'h7ffe12, 16'h0000, 24'h7ffe12, 16'habcd};
    rows[4] = '{16'h4004, 24'h7ffe20, 16'h0f0f, 24'h7ffe20, 16'h0f0f};
    rows[5] = '{16'h4059, 24'h7ffe16, 16'h0000, 24'h7ffe12, 16'hffff};
    rows[6] = '{16'h405a, 24'h7ffe2e, 16'h0000, 24'h7ffe20, 16'hffff};
    rows[7] = '{16'h4050, 24'h000000, 16'h0000, 24'h7ffe30, 16'hffff};
    rows[8] = '{16'h5004, 24'h7ffe30, 16'h0ff0, 24'h7ffe30, 16'h0ff0};
    rows[9] = '{16'h5005, 24'h7ffe30, 16'hf00f, 24'h7ffe30, 16'h0000};
    rows[10] = '{16'h4007, 24'h7ffe30, 16'hf00f, 24'h7ffe30, 16'hf00f};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ede_pkg::HR_STAT, s);
    chk(s, 32'h0);
    chk({15'h0, lnk.doneFlag, lnk.ctrlRd}, 32'h0);
    foreach (rows[i]) begin
      runOp(rows[i].ctrl, rows[i].addr, rows[i].data);
      waitIdle();
      chk({8'h00, addrUpper, addrLower}, {9'h000, rows[i].addr[22:1], 1'b0});
      rd(ede_pkg::HR_STAT, s);
      chk(s & 32'he, 32'h6);
      wr(ede_pkg::HR_ADDR, {8'h00, rows[i].rdAddr});
      wr(ede_pkg::HR_GO, 32'h2);
      waitIdle();
      rd(ede_pkg::HR_RDATA, s);
      chk(s, {16'h0000, rows[i].exp});
    end
    // Pin reset in the middle of a bulk erase
    runOp(16'h4050, 24'h0, 16'h0);
    for (int n = 0; n < 20 && lnk.ctrlRd[15] !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    earlyRst <= 1'b1;
    @(posedge ref_clk);
    earlyRst <= 1'b0;
    #1;
    chk({16'h0, lnk.ctrlRd & 16'he000}, 32'h2000);
    chk({31'h0, opBusy}, 32'h0);
    waitIdle();
    rd(ede_pkg::HR_STAT, s);
    chk(s & 32'he, 32'ha);
    // Start without the arm bit: refused, array untouched by the aborted erase
    runOp(16'h0058, 24'h7ffe30, 16'h0000);
    waitIdle();
    rd(ede_pkg::HR_STAT, s);
    chk(s & 32'he, 32'h2);
    wr(ede_pkg::HR_ADDR, 32'h007ffe30);
    wr(ede_pkg::HR_GO, 32'h2);
    waitIdle();
    rd(ede_pkg::HR_RDATA, s);
    chk(s, 32'h0000f00f);
    seq3(16'h0055, 16'h0011, 16'hc058);
    chk({16'h0, lnk2.ctrlRd}, 32'h4058);
    seq3(16'h0055, 16'h00aa, 16'h8059);
    chk({16'h0, lnk2.ctrlRd}, 32'h0059);
    seq3(16'h0055, 16'h00aa, 16'hc058);
    chk({16'h0, lnk2.ctrlRd}, 32'hc058);
    seq3(16'h0055, 16'h00aa, 16'hc05a);
    chk({16'h0, lnk2.ctrlRd & 16'h007f}, 32'h0058);
    for (int n = 0; n < 50 && lnk2.ctrlRd[15] !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({15'h0, lnk2.doneFlag, lnk2.ctrlRd}, 32'h10058);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
